/* hdl/wan_cell_transmit_outputs.sv */
// wan transmit cell bus output stage with wishbone control and a word fifo
// assumes the link clock and far-side pins are asynchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
`include "wan_tx_params.svh"

// Operation
// - transfer start strobe on first transfer cycle
// - strobe meaningful only in extended addressing
// - link outputs change only at link rising edges
// - cell start high with first cell word
// - master drives cell start and parity while enabled
// - master drives all sixteen data bits
// - slave drives marker, parity after enable
// - slave drives data one edge after enable
// - eight-bit mode: only low byte valid
// - selectable odd or even bus parity
// - master enable low on each edge a word moves
// - all pins released while interface disabled
// - slave answers only its own port, except on the transfer start pin
module wan_cell_transmit_outputs (
   input wire logic i_clk, // system clock, 200 MHz
   input wire logic i_rst, // async reset, high
   input wire logic i_wb_cyc, // wishbone cycle
   input wire logic i_wb_stb, // wishbone strobe
   input wire logic i_wb_we, // wishbone write
   input wire wan_tx_pkg::wb_adr_t i_wb_adr, // wishbone byte address
   input wire logic [3:0] i_wb_sel, // wishbone byte enables
   input wire logic [31:0] i_wb_dat, // wishbone write data
   output logic [31:0] o_wb_dat, // wishbone read data
   output logic o_wb_ack, // wishbone acknowledge
   input wire logic i_word_valid, // cell word offered
   input wire wan_tx_pkg::word_t i_word_data, // cell word
   input wire logic i_word_first, // first word of cell
   input wire logic i_word_last, // last word of cell
   output logic o_word_ready, // fifo can take a word
   input wire logic i_wan_tx_clock, // link clock pin
   output logic o_wan_tx_transfer_start, // transfer start strobe
   output logic o_wan_tx_transfer_start_oe, // its drive enable
   output logic o_wan_tx_cell_start, // cell start marker
   output logic o_wan_tx_cell_start_oe, // its drive enable
   output wan_tx_pkg::word_t o_wan_tx_word_bus, // link data bus
   output logic o_wan_tx_word_bus_oe, // bus drive enable
   output logic o_wan_tx_word_parity, // bus parity
   output logic o_wan_tx_word_parity_oe, // its drive enable
   input wire logic i_wan_tx_enable_n, // enable pin level, low active
   output logic o_wan_tx_enable_n, // enable driven as master
   output logic o_wan_tx_enable_n_oe, // enable drive enable
   input wire wan_tx_pkg::port_t i_wan_tx_port_select, // address pin level
   output wan_tx_pkg::port_t o_wan_tx_port_select, // address driven as master
   output logic o_wan_tx_port_select_oe, // address drive enable
   output logic o_wan_tx_cell_avail, // cell available as slave
   output logic o_wan_tx_cell_avail_oe // its drive enable
);
   import wan_tx_pkg::*;

   // ****************************************************************
   // state and fifo
   // ****************************************************************
   tx_state_t st_q;
   tx_state_t st_d;
   logic link_tick;
   logic pop;
   logic moved;
   logic go;
   logic head_valid;
   fifo_word_t head;
   fifo_cnt_t fifo_cnt;
   word_t head_data;
   logic head_first;
   logic head_last;

   assign link_tick = st_q.clk_s2 & ~st_q.clk_s3;
   assign head_data = head[`WTX_WORD_W-1:0];
   assign head_last = head[`WTX_WORD_W];
   assign head_first = head[`WTX_WORD_W+1];

   wan_tx_fifo #(
      .WIDTH(`WTX_FIFO_W),
      .DEPTH(`WTX_FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_valid(i_word_valid),
      .o_ready(o_word_ready),
      .i_data({i_word_first, i_word_last, i_word_data}),
      .o_valid(head_valid),
      .i_ready(pop),
      .o_data(head),
      .o_count(fifo_cnt)
   );

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_d = st_q;
      pop = 1'b0;
      moved = 1'b0;
      go = 1'b0;
      // two-flop synchronisers for the link pins
      st_d.clk_s1 = i_wan_tx_clock;
      st_d.clk_s2 = st_q.clk_s1;
      st_d.clk_s3 = st_q.clk_s2;
      st_d.en_s1 = i_wan_tx_enable_n;
      st_d.en_s2 = st_q.en_s1;
      st_d.ps_s1 = i_wan_tx_port_select;
      st_d.ps_s2 = st_q.ps_s1;

      // wishbone slave, one wait state, unmapped reads zero
      st_d.ack = i_wb_cyc & i_wb_stb & ~st_q.ack;
      if (st_d.ack) begin
         st_d.rdat = '0;
         if (i_wb_adr == `WTX_CTRL_ADR) begin
            st_d.rdat[`WTX_CTRL_EN_BIT] = st_q.if_en;
            st_d.rdat[`WTX_CTRL_MASTER_BIT] = st_q.master;
            st_d.rdat[`WTX_CTRL_WIDE_BIT] = st_q.wide;
            st_d.rdat[`WTX_CTRL_ODD_BIT] = st_q.odd;
            st_d.rdat[`WTX_CTRL_PREPEND_BIT] = st_q.prepend;
            st_d.rdat[`WTX_CTRL_PORT_MSB:`WTX_CTRL_PORT_LSB] = st_q.port;
            if (i_wb_we && i_wb_sel[0]) begin
               st_d.if_en = i_wb_dat[`WTX_CTRL_EN_BIT];
               st_d.master = i_wb_dat[`WTX_CTRL_MASTER_BIT];
               st_d.wide = i_wb_dat[`WTX_CTRL_WIDE_BIT];
               st_d.odd = i_wb_dat[`WTX_CTRL_ODD_BIT];
               st_d.prepend = i_wb_dat[`WTX_CTRL_PREPEND_BIT];
            end
            if (i_wb_we && i_wb_sel[1]) begin
               st_d.port = i_wb_dat[`WTX_CTRL_PORT_MSB:`WTX_CTRL_PORT_LSB];
            end
         end else if (i_wb_adr == `WTX_STATUS_ADR) begin
            st_d.rdat[`WTX_STAT_BUSY_BIT] = (st_q.state != ST_IDLE);
            st_d.rdat[`WTX_STAT_SEL_BIT] = st_q.sel;
            st_d.rdat[`WTX_STAT_DRIVE_BIT] = st_q.drive;
            st_d.rdat[`WTX_STAT_CNT_MSB:`WTX_STAT_CNT_LSB] = fifo_cnt;
         end
      end

      // link side, advanced only at link rising edges
      if (link_tick) begin
         st_d.tstart = 1'b0;
         st_d.sop = 1'b0;
         if (!st_q.if_en) begin
            st_d.state = ST_IDLE;
            st_d.drive = 1'b0;
            st_d.sel = 1'b0;
            st_d.enn = 1'b1;
            st_d.enn_oe = 1'b0;
            st_d.ps_oe = 1'b0;
            st_d.avail_oe = 1'b0;
            st_d.tstart_oe = 1'b0;
         end else if (st_q.master) begin
            go = 1'b1;
            st_d.drive = 1'b1;
            st_d.sel = 1'b0;
            st_d.tstart_oe = 1'b1;
            st_d.enn_oe = 1'b1;
            st_d.ps_oe = 1'b1;
            st_d.ps_out = st_q.port;
            st_d.avail_oe = 1'b0;
         end else begin
            st_d.enn_oe = 1'b0;
            st_d.ps_oe = 1'b0;
            st_d.tstart_oe = 1'b1;
            // address taken while enable high between cells
            if (st_q.en_s2 && st_q.state == ST_IDLE) begin
               st_d.sel = (st_q.ps_s2 == st_q.port);
            end
            st_d.avail_oe = (st_q.ps_s2 == st_q.port);
            st_d.avail = head_valid;
            go = st_q.sel & ~st_q.en_s2;
            if (go) begin
               st_d.drive = 1'b1;
            end else if (st_q.en_s2 && st_q.state == ST_IDLE) begin
               st_d.drive = 1'b0;
            end
         end

         if (go && head_valid) begin
            unique case (st_q.state)
               ST_IDLE: begin
                  if (!head_first) begin
                     pop = 1'b1;
                  end else if (st_q.prepend) begin
                     moved = 1'b1;
                     st_d.tstart = 1'b1;
                     st_d.word = {{(`WTX_WORD_W-`WTX_PORT_W){1'b0}}, st_q.port};
                     st_d.state = ST_ADDR;
                  end else begin
                     pop = 1'b1;
                     moved = 1'b1;
                     st_d.tstart = 1'b1;
                     st_d.sop = 1'b1;
                     st_d.word = head_data;
                     st_d.state = head_last ? ST_IDLE : ST_BODY;
                  end
               end
               ST_ADDR, ST_BODY: begin
                  pop = 1'b1;
                  moved = 1'b1;
                  st_d.sop = (st_q.state == ST_ADDR);
                  st_d.word = head_data;
                  st_d.state = head_last ? ST_IDLE : ST_BODY;
               end
               default: begin
                  st_d.state = ST_IDLE;
               end
            endcase
         end
         if (!st_q.wide) begin
            st_d.word[`WTX_WORD_W-1:8] = '0;
         end
         st_d.par = (^st_d.word) ^ st_q.odd;
         if (st_q.if_en && st_q.master) begin
            st_d.enn = ~moved;
         end
      end
   end

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= '0;
         st_q.en_s1 <= 1'b1;
         st_q.en_s2 <= 1'b1;
         st_q.enn <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_wb_dat = st_q.rdat;
   assign o_wb_ack = st_q.ack;
   assign o_wan_tx_transfer_start = st_q.tstart;
   assign o_wan_tx_transfer_start_oe = st_q.tstart_oe;
   assign o_wan_tx_cell_start = st_q.sop;
   assign o_wan_tx_cell_start_oe = st_q.drive;
   assign o_wan_tx_word_bus = st_q.word;
   assign o_wan_tx_word_bus_oe = st_q.drive;
   assign o_wan_tx_word_parity = st_q.par;
   assign o_wan_tx_word_parity_oe = st_q.drive;
   assign o_wan_tx_enable_n = st_q.enn;
   assign o_wan_tx_enable_n_oe = st_q.enn_oe;
   assign o_wan_tx_port_select = st_q.ps_out;
   assign o_wan_tx_port_select_oe = st_q.ps_oe;
   assign o_wan_tx_cell_avail = st_q.avail;
   assign o_wan_tx_cell_avail_oe = st_q.avail_oe;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_edge_only_update: assert property (
      !link_tick |=> $stable(o_wan_tx_word_bus) && $stable(o_wan_tx_cell_start)
         && $stable(o_wan_tx_word_parity) && $stable(o_wan_tx_word_bus_oe))
      else $error("link outputs changed away from a link edge");

   a_parity_sense: assert property (
      link_tick |=> o_wan_tx_word_parity == ((^o_wan_tx_word_bus) ^ $past(st_q.odd)))
      else $error("parity does not match bus and sense");

   a_master_drives: assert property (
      link_tick && st_q.if_en && st_q.master
      |=> o_wan_tx_word_bus_oe && o_wan_tx_cell_start_oe && o_wan_tx_word_parity_oe)
      else $error("master left a link output undriven");

   a_disabled_release: assert property (
      link_tick && !st_q.if_en |=> !o_wan_tx_word_bus_oe && !o_wan_tx_enable_n_oe
         && !o_wan_tx_transfer_start_oe && !o_wan_tx_port_select_oe)
      else $error("pins driven while disabled");

   a_slave_late_drive: assert property (
      $rose(o_wan_tx_word_bus_oe) && !st_q.master |-> $past(!st_q.en_s2 && st_q.sel))
      else $error("slave drove bus without enable sampled low");

   a_slave_own_port: assert property (
      link_tick && st_q.if_en && !st_q.master && !st_q.sel |=> !o_wan_tx_word_bus_oe)
      else $error("slave drove bus while not addressed");

   a_narrow_upper_zero: assert property (
      link_tick && !st_q.wide |=> o_wan_tx_word_bus[15:8] == 8'h00)
      else $error("upper byte not zero in narrow mode");

   a_first_word_marks: assert property (
      link_tick && go && head_valid && head_first && st_q.state == ST_IDLE
      |=> o_wan_tx_transfer_start && (o_wan_tx_cell_start == !$past(st_q.prepend)))
      else $error("cell start or transfer start misplaced");

   a_master_enable_low: assert property (
      link_tick && st_q.if_en && st_q.master && st_q.state == ST_BODY && head_valid
      |=> !o_wan_tx_enable_n)
      else $error("master enable high with data ready mid cell");

   c_master_cell: cover property (
      link_tick && st_q.master && st_q.state == ST_BODY && head_last);
   c_slave_cell: cover property (
      link_tick && !st_q.master && go && st_q.state == ST_BODY);
   c_prepend_cell: cover property (
      link_tick && st_q.state == ST_ADDR && head_valid);

endmodule // wan_cell_transmit_outputs

`default_nettype wire

/* hdl/wan_tx_fifo.sv */
// cell word fifo between the user stream and the link sequencer
// assumes one clock domain and an active high asynchronous reset
`timescale 1ns/1ps
`default_nettype none

module wan_tx_fifo #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 16
) (
   input wire logic i_clk, // system clock
   input wire logic i_rst, // async reset, high
   input wire logic i_valid, // write side valid
   output logic o_ready, // write side ready, registered
   input wire logic [WIDTH-1:0] i_data, // write data
   output logic o_valid, // read side valid, registered
   input wire logic i_ready, // read side ready
   output logic [WIDTH-1:0] o_data, // head word
   output logic [$clog2(DEPTH):0] o_count // words held
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic ready;
      logic valid;
   } fifo_state_t;

   fifo_state_t q;
   fifo_state_t d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign push = i_valid & q.ready;
   assign pop = i_ready & q.valid;

   always_comb begin
      d = q;
      if (push) begin
         d.wr = q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = q.rd + 1'b1;
      end
      d.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      d.ready = (d.cnt != (AW+1)'(DEPTH));
      d.valid = (d.cnt != '0);
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[q.wr] <= i_data;
      end
   end

   assign o_ready = q.ready;
   assign o_valid = q.valid;
   assign o_data = mem[q.rd];
   assign o_count = q.cnt;

endmodule // wan_tx_fifo

`default_nettype wire

/* pkg/wan_tx_params.svh */
// constants of the wan transmit output stage: register map, fields, resets, sizes
// assumes inclusion by bare name from the package and the design files
`ifndef WAN_TX_PARAMS_SVH
`define WAN_TX_PARAMS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define WTX_ADR_W 8
`define WTX_CTRL_ADR 8'h00
`define WTX_STATUS_ADR 8'h04

// ****************************************************************
// control register fields
// ****************************************************************
`define WTX_CTRL_EN_BIT 0
`define WTX_CTRL_MASTER_BIT 1
`define WTX_CTRL_WIDE_BIT 2
`define WTX_CTRL_ODD_BIT 3
`define WTX_CTRL_PREPEND_BIT 4
`define WTX_CTRL_PORT_LSB 8
`define WTX_CTRL_PORT_MSB 10
`define WTX_CTRL_RESET 32'h0000_0000

// ****************************************************************
// status register fields
// ****************************************************************
`define WTX_STAT_BUSY_BIT 0
`define WTX_STAT_SEL_BIT 1
`define WTX_STAT_DRIVE_BIT 2
`define WTX_STAT_CNT_LSB 8
`define WTX_STAT_CNT_MSB 12

// ****************************************************************
// sizes
// ****************************************************************
`define WTX_WORD_W 16
`define WTX_PORT_W 3
`define WTX_FIFO_DEPTH 16
`define WTX_FIFO_W 18
`define WTX_CNT_W 5

`endif

/* pkg/wan_tx_pkg.sv */
// types of the wan transmit output stage
// assumes wan_tx_params.svh on the include path
`include "wan_tx_params.svh"

package wan_tx_pkg;

   typedef logic [`WTX_WORD_W-1:0] word_t;
   typedef logic [`WTX_PORT_W-1:0] port_t;
   typedef logic [`WTX_ADR_W-1:0] wb_adr_t;
   typedef logic [`WTX_FIFO_W-1:0] fifo_word_t;
   typedef logic [`WTX_CNT_W-1:0] fifo_cnt_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ADDR,
      ST_BODY
   } cell_state_t;

   typedef struct packed {
      logic clk_s1;
      logic clk_s2;
      logic clk_s3;
      logic en_s1;
      logic en_s2;
      port_t ps_s1;
      port_t ps_s2;
      cell_state_t state;
      logic sel;
      logic drive;
      logic if_en;
      logic master;
      logic wide;
      logic odd;
      logic prepend;
      port_t port;
      logic ack;
      logic [31:0] rdat;
      logic tstart;
      logic tstart_oe;
      logic sop;
      word_t word;
      logic par;
      logic enn;
      logic enn_oe;
      port_t ps_out;
      logic ps_oe;
      logic avail;
      logic avail_oe;
   } tx_state_t;

endpackage

/* sim/test_wan_cell_transmit_outputs.sv */
// self-checking bench of the wan transmit output stage
// assumes wan_tx_pkg compiled first and wan_phy_model on the far side
`timescale 1ns/1ps
`default_nettype none

module test_wan_cell_transmit_outputs;
   import wan_tx_pkg::*;
   logic clk, lclk, lclk_d;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   wb_adr_t adr = 8'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat, q;
   logic ack, w_ready, tsx, tsx_oe, cs, cs_oe, bus_oe, par, par_oe, d_en_n, en_oe, ps_oe, av_oe;
   logic w_valid = 1'b0;
   logic w_first = 1'b0;
   logic w_last = 1'b0;
   word_t w_data = 16'h0000;
   word_t bus;
   port_t d_ps, p_adr;
   logic p_en_n;
   logic av;
   logic p_slave = 1'b0;
   logic mst_on = 1'b0;
   logic dis_on = 1'b0;
   logic [17:0] exp_q[$];
   logic [17:0] prev = 18'h0_0000;
   logic [31:0] rnd = 32'h0000_11e1;
   int since = 0;
   int n_mismatch = 0;
   int checked = 0;
   wire en_lvl = en_oe ? d_en_n : p_en_n;
   wire [2:0] ps_lvl = ps_oe ? d_ps : p_adr;

   wan_cell_transmit_outputs dut (
      .i_clk(clk), .i_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
      .i_word_valid(w_valid), .i_word_data(w_data), .i_word_first(w_first),
      .i_word_last(w_last), .o_word_ready(w_ready), .i_wan_tx_clock(lclk),
      .o_wan_tx_transfer_start(tsx), .o_wan_tx_transfer_start_oe(tsx_oe),
      .o_wan_tx_cell_start(cs), .o_wan_tx_cell_start_oe(cs_oe),
      .o_wan_tx_word_bus(bus), .o_wan_tx_word_bus_oe(bus_oe),
      .o_wan_tx_word_parity(par), .o_wan_tx_word_parity_oe(par_oe),
      .i_wan_tx_enable_n(en_lvl), .o_wan_tx_enable_n(d_en_n), .o_wan_tx_enable_n_oe(en_oe),
      .i_wan_tx_port_select(ps_lvl), .o_wan_tx_port_select(d_ps),
      .o_wan_tx_port_select_oe(ps_oe), .o_wan_tx_cell_avail(av),
      .o_wan_tx_cell_avail_oe(av_oe));

   wan_phy_model phy (.i_lclk(lclk), .i_slave(p_slave), .i_en_n(en_lvl), .i_oe(bus_oe),
      .i_bus(bus), .i_sop(cs), .i_tsx(tsx), .i_par(par), .o_en_n(p_en_n), .o_adr(p_adr));

   // ****************************************************************
   // clocks, watchdog, helpers
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   initial begin
      lclk = 1'b0;
      #3.3;
      forever #40 lclk = ~lclk;
   end

   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [31:0] ctrl(input logic [4:0] f, input port_t p);
      return {21'h0, p, 3'h0, f};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wb(input logic w, input wb_adr_t a, input logic [31:0] d);
      int t;
      t = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      // waits for ack however long; a hang is left to the watchdog
      do begin
         @(posedge clk);
         t++;
      end while (ack !== 1'b1);
      q = rdat;
      check(t, 2);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic push_cell(input int n, input logic pre, input logic wide, input port_t p);
      if (pre) exp_q.push_back({2'b10, 13'h0, p});
      for (int i = 0; i < n; i++) begin
         w_valid <= 1'b1;
         w_data <= rnd[15:0];
         w_first <= (i == 0);
         w_last <= (i == n - 1);
         exp_q.push_back({!pre && i == 0, i == 0, wide ? rnd[15:8] : 8'h00, rnd[7:0]});
         rnd = lfsr(rnd);
         do begin
            @(posedge clk);
         end while (w_ready !== 1'b1);
      end
      w_valid <= 1'b0;
   endtask

   task automatic cmp_cells(input logic odd, input logic m);
      logic [17:0] e;
      logic [18:0] c;
      check(phy.cap_q.size(), exp_q.size());
      while (exp_q.size() > 0 && phy.cap_q.size() > 0) begin
         e = exp_q.pop_front();
         c = phy.cap_q.pop_front();
         if (m) check(c[18], e[17]);
         check(c[17], e[16]);
         check(c[15:0], e[15:0]);
         check(c[16], ^e[15:0] ^ odd);
      end
      exp_q.delete();
      phy.cap_q.delete();
   endtask

   // ****************************************************************
   // pin monitors
   // ****************************************************************
   always @(posedge clk) begin
      lclk_d <= lclk;
      since <= (lclk && !lclk_d) ? 0 : since + 1;
      if ({bus, bus_oe, cs_oe} !== prev && !rst) check(since < 8, 1);
      prev <= {bus, bus_oe, cs_oe};
      if (mst_on) check({cs_oe, bus_oe, par_oe}, 3'b111);
      if (dis_on) check({tsx_oe, cs_oe, bus_oe, par_oe, en_oe, ps_oe, av_oe}, 0);
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      logic [4:0] f;
      int t;
      // release check armed once reset has reached the flops
      @(posedge clk);
      dis_on <= 1'b1;
      repeat (15) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      check(w_ready, 1);
      wb(1'b0, 8'h00, 0);
      check(q, 32'h0000_0000);
      wb(1'b0, 8'h08, 0);
      check(q, 32'h0000_0000);
      dis_on = 1'b0;
      for (int m = 0; m < 8; m++) begin
         f = {m[2], m[1], m[0], 2'b11};
         wb(1'b1, 8'h00, ctrl(f, 3'h6));
         wb(1'b0, 8'h00, 0);
         check(q, ctrl(f, 3'h6));
         repeat (40) @(posedge clk);
         mst_on = 1'b1;
         push_cell(1 + (m == 0 ? 0 : rnd[1:0]), m[2], m[0], 3'h6);
         t = 0;
         while (phy.cap_q.size() < exp_q.size() && t < 4000) begin
            @(posedge clk);
            t++;
         end
         repeat (40) @(posedge clk);
         cmp_cells(m[1], 1'b1);
         check({ps_oe, d_ps}, 4'he);
      end
      mst_on = 1'b0;
      wb(1'b1, 8'h00, 0);
      repeat (40) @(posedge clk);
      dis_on = 1'b1;
      repeat (100) @(posedge clk);
      dis_on = 1'b0;
      p_slave <= 1'b1;
      wb(1'b1, 8'h00, ctrl(5'b00101, 3'h5));
      push_cell(16, 1'b0, 1'b1, 3'h5);
      repeat (3) @(posedge clk);
      check(w_ready, 0);
      wb(1'b0, 8'h04, 0);
      check(q[12:8], 5'h10);
      phy.read_cell(3'h3, 16);
      @(posedge clk);
      wb(1'b0, 8'h04, 0);
      check(q[1], 0);
      check(phy.cap_q.size(), 0);
      check(av_oe, 0);
      phy.read_cell(3'h5, 16);
      @(posedge clk);
      cmp_cells(1'b0, 1'b0);
      check({cs_oe, bus_oe, par_oe}, 3'b000);
      check({av_oe, av}, 2'b10);
      wb(1'b0, 8'h04, 0);
      check(q[1], 1);
      check(q[12:8], 5'h00);
      check(w_ready, 1);
      wrap_up();
   end
endmodule // test_wan_cell_transmit_outputs

`default_nettype wire

/* sim/wan_phy_model.sv */
// far side of the wan transmit cell bus: takes words, drives enable and address as bus master
// assumes the bench supplies the free running link clock and reads cap_q by hierarchy
`timescale 1ns/1ps
`default_nettype none

module wan_phy_model (
   input wire logic i_lclk, // link clock
   input wire logic i_slave, // device is slave, model drives enable
   input wire logic i_en_n, // resolved enable pin
   input wire logic i_oe, // device drives data pins
   input wire logic [15:0] i_bus, // data bus
   input wire logic i_sop, // cell start marker
   input wire logic i_tsx, // transfer start strobe
   input wire logic i_par, // bus parity
   output logic o_en_n, // enable drive, idle high
   output logic [2:0] o_adr // address drive
);
   logic en_prev = 1'b1;
   logic [18:0] cap_q[$];

   initial begin
      o_en_n = 1'b1;
      o_adr = 3'h0;
   end

   // master: word valid with enable; slave: one link clock after enable
   always @(posedge i_lclk) begin
      if (i_oe && (i_slave ? !en_prev : !i_en_n)) begin
         cap_q.push_back({i_tsx, i_sop, i_par, i_bus});
      end
      en_prev <= i_en_n;
   end

   // pins move half a period off the sampling edge, clear of the device synchroniser
   task automatic read_cell(input logic [2:0] a, input int n);
      @(negedge i_lclk);
      o_adr <= a;
      repeat (2) @(negedge i_lclk);
      o_en_n <= 1'b0;
      repeat (n) @(negedge i_lclk);
      o_en_n <= 1'b1;
      repeat (3) @(negedge i_lclk);
   endtask
endmodule // wan_phy_model

`default_nettype wire
